//--- inc/acs_pkg.sv
// package: constants of the conversion sequencer
package acs_pkg;
    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int          CLK_HZ   = 100_000_000;
    localparam int          OSC_HZ   = 1_024_000;
    // phase accumulator ticks every half oscillator period
    localparam logic [31:0] PH_INC   = 32'(2 * OSC_HZ);
    localparam logic [31:0] PH_MOD   = 32'(CLK_HZ);
    localparam int          CNT_W    = 18;
    // ------------------------------------------------------------
    // conversion times in oscillator periods, slowest rate first
    // ------------------------------------------------------------
    // 51192, 11532, 3116, 1036
    localparam logic [16:0] CONT_CYC [4] = '{17'hC7F8, 17'h2D0C, 17'h0C2C, 17'h040C};
    // 51213, 11557, 3141, 1061
    localparam logic [16:0] SS_CYC   [4] = '{17'hC80D, 17'h2D25, 17'h0C45, 17'h0425};
    // start delay in tenths of an oscillator period, and in half periods
    localparam int              START_DLY_X10  = 285;
    localparam logic [CNT_W-1:0] START_DLY_HALF = CNT_W'(START_DLY_X10 * 2 / 10);
    // ready release ahead of the next completion, in oscillator periods
    localparam int              READY_REL_OSC  = 2;
    localparam logic [CNT_W-1:0] READY_REL_HALF = CNT_W'(READY_REL_OSC * 2);
    // ------------------------------------------------------------
    // power-on reset
    // ------------------------------------------------------------
    localparam int POR_US  = 500;
    localparam int POR_CYC = POR_US * (CLK_HZ / 1_000_000);
    // ------------------------------------------------------------
    // command bytes and configuration layout
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RESET_A  = 8'h06;
    localparam logic [7:0] CMD_RESET_B  = 8'h07;
    localparam logic [7:0] CMD_START    = 8'h08;
    localparam logic [7:0] CMD_SLEEP    = 8'h02;
    localparam logic [7:0] CMD_WREG     = 8'h40;
    localparam logic [6:0] GC_ADDR      = 7'h00;
    localparam logic [7:0] GC_RESET     = 8'h06;
    localparam logic [7:0] CFG_DEFAULT  = 8'h00;
    localparam int         CFG_MODE_POS = 1;
    localparam int         CFG_RATE_LSB = 2;
    localparam int         SYNC_W       = 10;
endpackage : acs_pkg

//--- core/acs_cmd_rx.sv
// module: serial command byte receiver with acknowledge drive
`timescale 1ns/1ps
module acs_cmd_rx (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_clr,
    // synchronised bus lines and address strap
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic [6:0] i_dev_addr,
    // decoded events
    output logic            o_byte_stb,
    output logic            o_byte_first,
    output logic            o_gc_reset,
    output logic            o_rd_stb,
    output logic [7:0]      o_byte,
    output logic            o_sda_oe
);
    logic       scl_d_r;
    logic       sda_d_r;
    logic       active_r;
    logic       ack_r;
    logic       addr_ph_r;
    logic       sel_r;
    logic       gc_r;
    logic       rd_r;
    logic       first_r;
    logic       lead_r;
    logic [2:0] bcnt_r;
    logic [7:0] shift_r;

    wire scl_fall   = scl_d_r & ~i_scl;
    wire scl_rise   = ~scl_d_r & i_scl;
    wire start_c    = i_scl & scl_d_r & sda_d_r & ~i_sda;
    wire stop_c     = i_scl & scl_d_r & ~sda_d_r & i_sda;
    wire addr_match = shift_r[7:1] == i_dev_addr;
    wire is_gc      = (shift_r[7:1] == acs_pkg::GC_ADDR) & ~shift_r[0];
    wire ack_en     = addr_ph_r ? (addr_match | is_gc) : (sel_r & ~rd_r);

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scl_d_r <= 1'b1; sda_d_r <= 1'b1; active_r <= 1'b0; ack_r <= 1'b0;
            addr_ph_r <= 1'b0; sel_r <= 1'b0; gc_r <= 1'b0; rd_r <= 1'b0;
            first_r <= 1'b0; bcnt_r <= 3'h0; shift_r <= 8'h00; o_byte <= 8'h00;
            lead_r <= 1'b0;
            o_byte_stb <= 1'b0; o_byte_first <= 1'b0; o_gc_reset <= 1'b0;
            o_rd_stb <= 1'b0; o_sda_oe <= 1'b0;
        end else begin
            scl_d_r    <= i_scl;
            sda_d_r    <= i_sda;
            o_byte_stb <= 1'b0;
            o_gc_reset <= 1'b0;
            o_rd_stb   <= 1'b0;
            if (i_clr | stop_c) begin
                active_r <= 1'b0;
                ack_r    <= 1'b0;
                o_sda_oe <= 1'b0;
            end else if (start_c) begin
                active_r  <= 1'b1;
                ack_r     <= 1'b0;
                addr_ph_r <= 1'b1;
                lead_r    <= 1'b1;
                sel_r     <= 1'b0;
                bcnt_r    <= 3'h0;
                o_sda_oe  <= 1'b0;
            end else if (active_r) begin
                if (scl_rise & ~ack_r) begin
                    shift_r <= {shift_r[6:0], i_sda};
                end
                if (scl_fall) begin
                    if (lead_r) begin
                        // the fall that follows start carries no bit and is not counted
                        lead_r <= 1'b0;
                    end else if (ack_r) begin
                        ack_r    <= 1'b0;
                        o_sda_oe <= 1'b0;
                        bcnt_r   <= 3'h0;
                        active_r <= sel_r;
                    end else if (bcnt_r == 3'h7) begin
                        // eighth falling edge: byte complete
                        ack_r    <= 1'b1;
                        o_sda_oe <= ack_en;
                        o_byte   <= shift_r;
                        if (addr_ph_r) begin
                            addr_ph_r <= 1'b0;
                            sel_r     <= addr_match | is_gc;
                            gc_r      <= is_gc;
                            rd_r      <= shift_r[0];
                            o_rd_stb  <= addr_match & shift_r[0];
                            first_r   <= 1'b1;
                        end else if (sel_r & ~rd_r) begin
                            if (gc_r) begin
                                o_gc_reset <= shift_r == acs_pkg::GC_RESET;
                            end else begin
                                o_byte_stb   <= 1'b1;
                                o_byte_first <= first_r;
                                first_r      <= 1'b0;
                            end
                        end
                    end else begin
                        bcnt_r <= bcnt_r + 3'h1;
                    end
                end
            end
        end
    end
endmodule : acs_cmd_rx

//--- core/acs_top.sv
// module: conversion sequencer top with reset, timing and ready logic
`timescale 1ns/1ps
module acs_top #(
    parameter int POR_CYC = acs_pkg::POR_CYC
) (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_nrst,
    // device pins
    input  wire logic        i_reset_pin_n,
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    input  wire logic [6:0]  i_dev_addr,
    output logic             o_sda_o,
    output logic             o_sda_oe,
    output logic             o_result_ready_n,
    // converter side
    input  wire logic [15:0] i_sample,
    output logic [15:0]      o_result_buf,
    output logic [15:0]      o_tx_word,
    // status and configuration
    output logic [7:0]       o_cfg,
    output logic             o_analog_on,
    output logic             o_comm_ready
);
    localparam int W = acs_pkg::CNT_W;

    typedef enum logic [1:0] {ST_POR, ST_SLEEP, ST_CONV} acs_state_t;

    // ------------------------------------------------------------
    // reset release and pin synchronisers
    // ------------------------------------------------------------
    logic rst_m_r;
    logic rst_n_r;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_m_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            rst_n_r <= rst_m_r;
        end
    end

    logic [acs_pkg::SYNC_W-1:0] sync1_r;
    logic [acs_pkg::SYNC_W-1:0] sync2_r;
    wire  [acs_pkg::SYNC_W-1:0] pins = {i_reset_pin_n, i_scl, i_sda, i_dev_addr};

    generate
        for (genvar g = 0; g < acs_pkg::SYNC_W; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge rst_n_r) begin
                if (!rst_n_r) begin
                    sync1_r[g] <= 1'b1;
                    sync2_r[g] <= 1'b1;
                end else begin
                    sync1_r[g] <= pins[g];
                    sync2_r[g] <= sync1_r[g];
                end
            end
        end
    endgenerate

    wire       pin_n_s = sync2_r[9];
    wire       scl_s   = sync2_r[8];
    wire       sda_s   = sync2_r[7];
    wire [6:0] addr_s  = sync2_r[6:0];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    acs_state_t  state_r;
    logic [31:0] por_cnt_r;
    logic [31:0] acc_r;
    logic [W-1:0] cnt_r;
    logic [7:0]  cfg_r;
    logic [1:0]  rate_r;
    logic        mode_r;
    logic        first_r;
    logic        sleep_pend_r;
    logic        wreg_pend_r;
    logic        ready_n_r;
    logic [15:0] result_r;
    logic [15:0] tx_r;
    logic        analog_r;
    logic        comm_r;
    logic        sda_o_r;

    // ------------------------------------------------------------
    // command receiver
    // ------------------------------------------------------------
    logic       rx_stb;
    logic       rx_first;
    logic       rx_gc;
    logic       rx_rd;
    logic [7:0] rx_byte;
    logic       rx_oe;

    wire in_por = state_r == ST_POR;
    wire conv   = state_r == ST_CONV;

    acs_cmd_rx u_rx (
        .i_clk        (i_clk),
        .i_rst_n      (rst_n_r),
        .i_clr        (~pin_n_s | in_por),
        .i_scl        (scl_s),
        .i_sda        (sda_s),
        .i_dev_addr   (addr_s),
        .o_byte_stb   (rx_stb),
        .o_byte_first (rx_first),
        .o_gc_reset   (rx_gc),
        .o_rd_stb     (rx_rd),
        .o_byte       (rx_byte),
        .o_sda_oe     (rx_oe)
    );

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire cmd_first = rx_stb & rx_first;
    wire cmd_rst   = cmd_first & ((rx_byte == acs_pkg::CMD_RESET_A)
                                | (rx_byte == acs_pkg::CMD_RESET_B));
    wire start_c   = cmd_first & (rx_byte == acs_pkg::CMD_START);
    wire sleep_c   = cmd_first & (rx_byte == acs_pkg::CMD_SLEEP);
    wire wreg_c    = cmd_first & (rx_byte == acs_pkg::CMD_WREG);
    wire cfg_wr    = rx_stb & ~rx_first & wreg_pend_r;
    // pin, command and general-call resets all act in the same cycle
    wire clr_all   = ~pin_n_s | cmd_rst | rx_gc;

    wire [7:0] cfg_use     = cfg_wr ? rx_byte : cfg_r;
    wire [1:0] rate_use    = cfg_use[acs_pkg::CFG_RATE_LSB +: 2];
    // mode bit only takes effect with begin-conversion; a write alone keeps the running mode
    wire       launch_mode = start_c ? cfg_r[acs_pkg::CFG_MODE_POS] : mode_r;
    wire       launch      = start_c | (cfg_wr & conv & ~mode_r);
    wire       restart_ct  = cfg_wr & conv & mode_r & ~start_c;

    wire [W-1:0] cont_half  = {acs_pkg::CONT_CYC[rate_use], 1'b0};
    wire [W-1:0] ss_half    = {acs_pkg::SS_CYC[rate_use], 1'b0};
    wire [W-1:0] run_half   = {acs_pkg::CONT_CYC[rate_r], 1'b0};
    wire [W-1:0] launch_cnt = launch_mode ? acs_pkg::START_DLY_HALF + cont_half : ss_half;

    // ------------------------------------------------------------
    // oscillator: half-period ticks from a phase accumulator
    // ------------------------------------------------------------
    wire [31:0] acc_sum  = acc_r + acs_pkg::PH_INC;
    wire        tick     = conv & (acc_sum >= acs_pkg::PH_MOD);
    wire [31:0] acc_nxt  = tick ? acc_sum - acs_pkg::PH_MOD : acc_sum;
    wire        done     = tick & (cnt_r == W'(1));
    wire        done_eff = done & ~launch & ~restart_ct & ~clr_all;
    wire        to_sleep = ~mode_r | sleep_pend_r | sleep_c;
    // unread result: ready lets go shortly before the next one lands
    wire        release_c = mode_r & conv & (cnt_r <= acs_pkg::READY_REL_HALF);

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_POR; por_cnt_r <= 32'h0; acc_r <= 32'h0; cnt_r <= '0;
            cfg_r <= acs_pkg::CFG_DEFAULT; rate_r <= 2'h0; mode_r <= 1'b0;
            first_r <= 1'b0; sleep_pend_r <= 1'b0; wreg_pend_r <= 1'b0;
            ready_n_r <= 1'b1; result_r <= 16'h0000; tx_r <= 16'h0000;
        end else if (in_por) begin
            por_cnt_r <= por_cnt_r + 32'h1;
            if (por_cnt_r == 32'(POR_CYC - 1)) begin
                state_r <= ST_SLEEP;
            end
        end else if (clr_all) begin
            state_r      <= ST_SLEEP;
            cfg_r        <= acs_pkg::CFG_DEFAULT;
            mode_r       <= 1'b0;
            acc_r        <= 32'h0;
            cnt_r        <= '0;
            sleep_pend_r <= 1'b0;
            wreg_pend_r  <= 1'b0;
            ready_n_r    <= 1'b1;
        end else begin
            if (rx_stb) begin
                wreg_pend_r <= wreg_c;
            end
            if (cfg_wr) begin
                cfg_r <= rx_byte;
            end
            if (launch) begin
                state_r      <= ST_CONV;
                mode_r       <= launch_mode;
                rate_r       <= rate_use;
                cnt_r        <= launch_cnt;
                acc_r        <= 32'h0;
                first_r      <= launch_mode;
                sleep_pend_r <= 1'b0;
            end else if (restart_ct) begin
                rate_r  <= rate_use;
                cnt_r   <= cont_half;
                acc_r   <= 32'h0;
                first_r <= 1'b0;
            end else if (conv) begin
                acc_r <= acc_nxt;
                if (sleep_c) begin
                    sleep_pend_r <= 1'b1;
                end
                if (done) begin
                    result_r <= i_sample;
                    first_r  <= 1'b0;
                    cnt_r    <= run_half;
                    if (to_sleep) begin
                        state_r <= ST_SLEEP;
                    end
                end else if (tick) begin
                    cnt_r <= cnt_r - W'(1);
                end
            end
            // new result wins over a read in the same cycle
            if (done_eff) begin
                ready_n_r <= 1'b0;
            end else if (rx_rd | release_c) begin
                ready_n_r <= 1'b1;
            end
            if (rx_rd) begin
                tx_r <= result_r;
            end
        end
    end

    // output copies lag state by one cycle so every output leaves a flop
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            analog_r <= 1'b0;
            comm_r   <= 1'b0;
            sda_o_r  <= 1'b0;
        end else begin
            analog_r <= conv;
            comm_r   <= ~in_por;
            sda_o_r  <= 1'b0;
        end
    end

    assign o_sda_o          = sda_o_r;
    assign o_sda_oe         = rx_oe;
    assign o_result_ready_n = ready_n_r;
    assign o_result_buf     = result_r;
    assign o_tx_word        = tx_r;
    assign o_cfg            = cfg_r;
    assign o_analog_on      = analog_r;
    assign o_comm_ready     = comm_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [W-1:0] hlp_r;

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            hlp_r <= '0;
        end else if (launch | restart_ct | done | clr_all | ~conv) begin
            hlp_r <= '0;
        end else if (tick) begin
            hlp_r <= hlp_r + W'(1);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n_r);

    property p_ss_time;
        done_eff & ~mode_r |-> (hlp_r + W'(1)) == {acs_pkg::SS_CYC[rate_r], 1'b0};
    endproperty
    a_ss_time: assert property (p_ss_time) else $error("single-shot time wrong");

    property p_first_delay;
        done_eff & mode_r & first_r |-> (hlp_r + W'(1)) == acs_pkg::START_DLY_HALF + run_half;
    endproperty
    a_first_delay: assert property (p_first_delay) else $error("start delay wrong");

    property p_cont_period;
        done_eff & mode_r & ~first_r |-> (hlp_r + W'(1)) == run_half;
    endproperty
    a_cont_period: assert property (p_cont_period) else $error("continuous period wrong");

    property p_reset_state;
        clr_all & ~in_por |=> state_r == ST_SLEEP && cfg_r == acs_pkg::CFG_DEFAULT && ready_n_r ##1 !o_analog_on;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("reset did not idle");

    property p_ss_sleep;
        done_eff & ~mode_r |=> state_r == ST_SLEEP && !ready_n_r ##1 !o_analog_on;
    endproperty
    a_ss_sleep: assert property (p_ss_sleep) else $error("single-shot did not sleep");

    property p_cont_next;
        done_eff & ~to_sleep |=> state_r == ST_CONV && !o_result_ready_n && o_result_buf == $past(i_sample);
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("continuous did not go on");

    sequence s_pend;
        sleep_c & conv & ~done & ~clr_all & ~launch & ~restart_ct;
    endsequence
    property p_sleep_finish;
        s_pend |=> state_r == ST_CONV && sleep_pend_r;
    endproperty
    a_sleep_finish: assert property (p_sleep_finish) else $error("sleep cut conversion");

    property p_sleep_idle;
        state_r == ST_SLEEP & ~launch & ~cfg_wr & ~clr_all |=> state_r == ST_SLEEP && $stable(cfg_r);
    endproperty
    a_sleep_idle: assert property (p_sleep_idle) else $error("converted while asleep");

    property p_wake;
        start_c & ~clr_all & state_r == ST_SLEEP |=> state_r == ST_CONV
            && mode_r == $past(cfg_r[acs_pkg::CFG_MODE_POS]);
    endproperty
    a_wake: assert property (p_wake) else $error("begin-conversion did not wake");

    property p_read_release;
        rx_rd & ~done_eff & ~clr_all & ~in_por |=> o_result_ready_n && o_tx_word == $past(result_r);
    endproperty
    a_read_release: assert property (p_read_release) else $error("read did not release ready");

    property p_restart_ss;
        cfg_wr & conv & ~mode_r & ~start_c & ~clr_all |=> hlp_r == '0 && cnt_r == {acs_pkg::SS_CYC[rate_r], 1'b0};
    endproperty
    a_restart_ss: assert property (p_restart_ss) else $error("config write did not restart");
endmodule : acs_top

//--- sim/acs_host_model.sv
// serial bus host model that sends command frames to the sequencer
`timescale 1ns/1ps
module acs_host_model (
    input  wire logic i_clk,
    output logic      o_scl,
    output logic      o_sda_low
);
    // ------------------------------------------------------------
    // bit and frame tasks, scl period 8 clk
    // ------------------------------------------------------------
    longint t_latch;
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // msb first; i == -1 is the ack slot with sda released
    task automatic put(input logic [7:0] b);
        for (int i = 7; i >= -1; i--) begin
            o_sda_low <= (i >= 0) ? ~b[i] : 1'b0;
            repeat (2) @(posedge i_clk);
            o_scl <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_scl <= 1'b0;
            if (i == 0) t_latch = $time;
            repeat (2) @(posedge i_clk);
        end
    endtask : put
    // one frame: address byte a, then n data bytes (0 to 2)
    task automatic xfer(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1, input int n);
        o_sda_low <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_scl <= 1'b0;
        repeat (2) @(posedge i_clk);
        put(a);
        if (n > 0) put(b0);
        if (n > 1) put(b1);
        o_sda_low <= 1'b1;
        repeat (2) @(posedge i_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_clk);
        o_sda_low <= 1'b0;
        repeat (8) @(posedge i_clk);
    endtask : xfer
    task automatic send(input logic [7:0] b0, input logic [7:0] b1, input bit two);
        xfer(8'h90, b0, b1, two ? 2 : 1);
    endtask : send
endmodule : acs_host_model

//--- sim/tb_acs_top.sv
// self-checking bench of the conversion sequencer top
`timescale 1ns/1ps
module tb_acs_top;
    logic        i_clk = 1'b0, i_nrst = 1'b0, i_reset_pin_n = 1'b1;
    logic [15:0] i_sample = 16'h0000, rbuf, txw;
    logic        scl, sda_low, sda_o, sda_oe, rdy_n, an_on, comm;
    logic [7:0]  cfg;
    logic [31:0] rng = 32'h253C;
    wire         sda = ~(sda_low | (sda_oe & ~sda_o));
    int          err_count = 0, n_checks = 0, cyc = 0;
    longint      dt, ex;
    always #5 i_clk = ~i_clk;
    acs_host_model u_host (.i_clk(i_clk), .o_scl(scl), .o_sda_low(sda_low));
    acs_top #(.POR_CYC(20)) u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reset_pin_n(i_reset_pin_n),
        .i_scl(scl), .i_sda(sda), .i_dev_addr(7'h48), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .o_result_ready_n(rdy_n), .i_sample(i_sample), .o_result_buf(rbuf), .o_tx_word(txw),
        .o_cfg(cfg), .o_analog_on(an_on), .o_comm_ready(comm));
    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // single-shot run at the fastest rate is about 104k cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 130000) begin
            err_count++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (40) @(posedge i_clk);
        chk("comm_ready", 1, comm);
        chk("ready_n", 1, rdy_n);
        chk("cfg", 0, cfg);
        rng = xs(rng);
        i_sample <= rng[15:0];
        u_host.send(8'h40, 8'h0C, 1'b1);
        chk("cfg", 32'h0C, cfg);
        u_host.send(8'h08, 8'h00, 1'b0);
        chk("analog_on", 1, an_on);
        u_host.send(8'h40, 8'h0C, 1'b1);
        chk("analog_on", 1, an_on);
        ex = (longint'(acs_pkg::SS_CYC[3]) * 100000 + 1023) / 1024;
        while (rdy_n === 1'b1 && ($time - u_host.t_latch) / 10 < ex + 50) @(posedge i_clk);
        dt = ($time - u_host.t_latch) / 10;
        chk("ss_time", 1, dt >= ex - 2 && dt <= ex + 8);
        chk("result_buf", {16'h0, rng[15:0]}, rbuf);
        chk("ready_n", 0, rdy_n);
        u_host.xfer(8'h91, 8'h00, 8'h00, 0);
        chk("tx_word", {16'h0, rng[15:0]}, txw);
        chk("ready_n", 1, rdy_n);
        repeat (20) @(posedge i_clk);
        chk("analog_on", 0, an_on);
        for (int k = 0; k < 2; k++) begin
            u_host.send(8'h40, 8'h0E, 1'b1);
            u_host.send(8'h08, 8'h00, 1'b0);
            repeat (100) @(posedge i_clk);
            chk("analog_on", 1, an_on);
            u_host.send(8'h40, 8'h0E, 1'b1);
            chk("analog_on", 1, an_on);
            u_host.send(8'h02, 8'h00, 1'b0);
            chk("analog_on", 1, an_on);
            u_host.send(8'h06 + 8'(k), 8'h00, 1'b0);
            chk("analog_on", 0, an_on);
            chk("cfg", 0, cfg);
            chk("ready_n", 1, rdy_n);
        end
        u_host.send(8'h40, 8'h0C, 1'b1);
        chk("cfg", 32'h0C, cfg);
        u_host.xfer(8'h00, 8'h06, 8'h00, 1);
        chk("cfg", 0, cfg);
        u_host.send(8'h40, 8'h0C, 1'b1);
        i_reset_pin_n <= 1'b0;
        repeat (6) @(posedge i_clk);
        i_reset_pin_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        chk("cfg", 0, cfg);
        test_done();
    end
endmodule : tb_acs_top
